// File: seq_pkg.sv
// Shared types and constants for the step-down sequencing core.
// Assumes a single 20 MHz clock domain and comparator inputs already synchronous.
`default_nettype none
package seq_pkg;

  timeunit 1ns;
  timeprecision 1ns;

  localparam int          CLK_HZ            = 20_000_000;
  localparam logic [2:0]  QUAL_TARGET       = 3'h7;
  localparam logic [2:0]  QUAL_ZERO         = 3'h0;
  localparam int          RAMP_DONE_PCT     = 90;
  localparam int          SHUTDOWN_MV       = 125;
  localparam int          ENABLE_MV         = 210;
  localparam int          SWITCH_MV         = 850;
  localparam logic [1:0]  SYNC_EDGE_PATTERN = 2'h1;

  typedef enum logic [1:0] {
    VAR_SOURCE_ONLY = 2'b00,
    VAR_SOURCE_SINK = 2'b01,
    VAR_PREBIAS     = 2'b10
  } variant_t;

  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_LOCKOUT = 2'b01,
    ST_RUN     = 2'b10
  } seq_state_t;

  // Soft-start node level indications from the analog comparators
  typedef struct packed {
    logic above_enable;
    logic above_shutdown_n;
    logic above_switch;
  } ss_level_t;

  typedef struct packed {
    logic high_side_en;
    logic low_side_en;
  } gate_en_t;

endpackage : seq_pkg
`default_nettype wire

// File: qual_counter.sv
// Three-bit saturating qualification counter.
// Assumes cycle_tick_i is a one-cycle strobe per oscillator period.
`default_nettype none
module qual_counter (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       cycle_tick_i,
  input  wire logic       count_cond_i,
  input  wire logic       clear_i,
  output logic            done_o
);

  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] count_r;
  logic [2:0] count_nxt;
  wire        at_target = (count_r == seq_pkg::QUAL_TARGET);

  // Opposite class clears, target saturates
  assign count_nxt = clear_i                   ? seq_pkg::QUAL_ZERO :
                     !cycle_tick_i              ? count_r :
                     !count_cond_i              ? seq_pkg::QUAL_ZERO :
                     at_target                  ? count_r :
                     count_r + 3'h1;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_r <= seq_pkg::QUAL_ZERO;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign done_o = at_target;

endmodule : qual_counter
`default_nettype wire

// File: buck_undervoltage_lockout_startup_sequencer.sv
// Sequencing core: undervoltage qualification, soft-start release and gate enables.
// Assumes all comparator and pin inputs are synchronous to ref_clk_i.
// Assumes variant_i is strapped and never changes while the core runs.
`default_nettype none
module buck_undervoltage_lockout_startup_sequencer (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 osc_pulse_i,
  input  wire logic                 sync_in_i,
  input  wire logic                 ramp_at_90pct_i,
  input  wire seq_pkg::ss_level_t   ss_level_i,
  input  wire seq_pkg::variant_t    variant_i,
  input  wire logic                 pwm_high_i,
  input  wire logic                 zero_current_i,
  output logic                      osc_sync_o,
  output logic                      ramp_start_o,
  output logic                      power_good_o,
  output logic                      ss_discharge_o,
  output logic                      core_enable_o,
  output logic                      uv_cycle_o,
  output seq_pkg::gate_en_t         gate_en_o
);

  timeunit 1ns;
  timeprecision 1ns;

  seq_pkg::seq_state_t state_r;
  seq_pkg::seq_state_t state_nxt;
  logic                en_r;
  logic                en_nxt;
  logic                sync_d_r;
  logic                hs_seen_r;
  logic                hs_seen_nxt;
  logic                uv_cycle_r;
  logic                uv_cycle_nxt;
  logic                pg_r;
  logic                pg_nxt;
  seq_pkg::gate_en_t   gate_r;
  seq_pkg::gate_en_t   gate_nxt;

  // Run-phase decode, shared by the state, power-good and drive paths
  function automatic logic is_run(input seq_pkg::seq_state_t s);
    return (s == seq_pkg::ST_RUN);
  endfunction : is_run

  // Debounce verdicts: each tally needs seven like cycles in a row
  wire good_done;
  wire bad_done;
  wire cycle_good = ramp_at_90pct_i;
  // Phase decodes
  wire in_lockout = (state_r == seq_pkg::ST_LOCKOUT);
  wire in_run     = is_run(state_r);
  // Low mark acts at once, so power good never outlives the shutdown edge
  wire shut_now   = !ss_level_i.above_shutdown_n;

  // Shutdown hysteresis: off at or below low mark, on at or above high mark
  assign en_nxt = shut_now                     ? 1'b0 :
                  ss_level_i.above_enable      ? 1'b1 :
                  en_r;

  // Good tally runs only in lockout; any other phase holds it at zero
  qual_counter u_good_cnt (
    .ref_clk_i    (ref_clk_i),
    .rst_b_i      (rst_b_i),
    .cycle_tick_i (osc_pulse_i),
    .count_cond_i (cycle_good),
    .clear_i      (!in_lockout),
    .done_o       (good_done)
  );

  // Bad tally runs only in run, so a restart never inherits old counts
  qual_counter u_bad_cnt (
    .ref_clk_i    (ref_clk_i),
    .rst_b_i      (rst_b_i),
    .cycle_tick_i (osc_pulse_i),
    .count_cond_i (!cycle_good),
    .clear_i      (!in_run),
    .done_o       (bad_done)
  );

  // Off: core idle; lockout: input being qualified; run: soft-start released
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      seq_pkg::ST_OFF: begin
        if (en_r && !shut_now) begin
          state_nxt = seq_pkg::ST_LOCKOUT;
        end
      end
      seq_pkg::ST_LOCKOUT: begin
        if (!en_r || shut_now) begin
          state_nxt = seq_pkg::ST_OFF;
        end else if (good_done) begin
          state_nxt = seq_pkg::ST_RUN;
        end
      end
      seq_pkg::ST_RUN: begin
        if (!en_r || shut_now) begin
          state_nxt = seq_pkg::ST_OFF;
        end else if (bad_done) begin
          state_nxt = seq_pkg::ST_LOCKOUT;
        end
      end
      default: begin
        // Unused code falls back to off
        state_nxt = seq_pkg::ST_OFF;
      end
    endcase
  end

  // Drives may switch only in run, above the switching level
  wire switching = in_run && is_run(state_nxt)
                   && ss_level_i.above_switch;

  // Rectifier gating per variant; zero-current input only meaningful for source-only
  wire prebias_mode = (variant_i == seq_pkg::VAR_PREBIAS);
  wire source_only  = (variant_i == seq_pkg::VAR_SOURCE_ONLY);
  wire ls_allowed   = prebias_mode ? hs_seen_r :
                      source_only  ? !zero_current_i :
                      1'b1;

  // Drive enables follow the modulator phase only while switching is allowed
  assign gate_nxt.high_side_en = switching && pwm_high_i;
  assign gate_nxt.low_side_en  = switching && !pwm_high_i && ls_allowed;

  // Rectifier permission is forgotten on leaving run, so every restart waits again
  assign hs_seen_nxt  = in_run && (hs_seen_r || gate_nxt.high_side_en);
  // Class holds between pulses so the last verdict stays visible
  assign uv_cycle_nxt = osc_pulse_i ? !cycle_good : uv_cycle_r;
  assign pg_nxt       = is_run(state_nxt);

  // Sequencer state
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= seq_pkg::ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Enable hysteresis flop
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
    end
  end

  // One-stage history for sync edges; idles low like a grounded pin
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_d_r <= 1'b0;
    end else begin
      sync_d_r <= sync_in_i;
    end
  end

  // Set once the high side has been driven in this run
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hs_seen_r <= 1'b0;
    end else begin
      hs_seen_r <= hs_seen_nxt;
    end
  end

  // Last oscillator cycle class
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      uv_cycle_r <= 1'b0;
    end else begin
      uv_cycle_r <= uv_cycle_nxt;
    end
  end

  // From the next state, so power good and run begin on one edge
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pg_r <= 1'b0;
    end else begin
      pg_r <= pg_nxt;
    end
  end

  // Registered drives; gates stay off on the edge that enters run
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gate_r <= '0;
    end else begin
      gate_r <= gate_nxt;
    end
  end

  // Rising sync edge retimes the oscillator; grounded input gives no edges
  assign osc_sync_o     = ({sync_d_r, sync_in_i} == seq_pkg::SYNC_EDGE_PATTERN);
  assign ramp_start_o   = osc_pulse_i;
  assign power_good_o   = pg_r;
  assign ss_discharge_o = !pg_r;
  assign core_enable_o  = en_r;
  assign uv_cycle_o     = uv_cycle_r;
  assign gate_en_o      = gate_r;

endmodule : buck_undervoltage_lockout_startup_sequencer
`default_nettype wire

// File: seq_props.sv
// Port-level checks for the sequencing core.
// Assumes one clock domain and binding onto the core.
`default_nettype none
module seq_props (
  input wire logic               ref_clk_i,
  input wire logic               rst_b_i,
  input wire logic               osc_pulse_i,
  input wire logic               ramp_at_90pct_i,
  input wire seq_pkg::ss_level_t ss_level_i,
  input wire seq_pkg::variant_t  variant_i,
  input wire logic               zero_current_i,
  input wire logic               ramp_start_o,
  input wire logic               power_good_o,
  input wire logic               ss_discharge_o,
  input wire logic               core_enable_o,
  input wire logic               uv_cycle_o,
  input wire seq_pkg::gate_en_t  gate_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  ramp_launch_a: assert property (ramp_start_o == osc_pulse_i) else $error("ramp start off");
  uv_class_a: assert property (osc_pulse_i |=> uv_cycle_o == !$past(ramp_at_90pct_i))
    else $error("cycle class wrong");
  discharge_hold_a: assert property (ss_discharge_o == !power_good_o) else $error("discharge wrong");
  shut_down_a: assert property (!ss_level_i.above_shutdown_n |=> !core_enable_o && !power_good_o)
    else $error("not shut down");
  core_wake_a: assert property (ss_level_i.above_enable |=> core_enable_o) else $error("core not on");
  start_gates_a: assert property ($rose(power_good_o) |-> gate_en_o == 2'h0) else $error("gates on");
  // Seventh pulse lies two samples before the sampled change of power good
  good_cause_a: assert property ($rose(power_good_o) |-> $past(osc_pulse_i && ramp_at_90pct_i, 2))
    else $error("power good without pulse");
  bad_cause_a: assert property ($fell(power_good_o) && core_enable_o
    |-> $past(osc_pulse_i && !ramp_at_90pct_i, 2)) else $error("lockout without pulse");
  switch_stop_a: assert property (!ss_level_i.above_switch |=> gate_en_o == 2'h0) else $error("still switching");
  zero_cur_a: assert property (variant_i == seq_pkg::VAR_SOURCE_ONLY && zero_current_i
    |=> !gate_en_o.low_side_en) else $error("rectifier on");
endmodule : seq_props
bind buck_undervoltage_lockout_startup_sequencer seq_props seq_props_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .osc_pulse_i(osc_pulse_i), .ramp_at_90pct_i(ramp_at_90pct_i), .ss_level_i(ss_level_i), .variant_i(variant_i),
  .zero_current_i(zero_current_i), .ramp_start_o(ramp_start_o), .power_good_o(power_good_o),
  .ss_discharge_o(ss_discharge_o), .core_enable_o(core_enable_o), .uv_cycle_o(uv_cycle_o), .gate_en_o(gate_en_o));
`default_nettype wire

// File: osc_ramp_model.sv
// Oscillator and ramp comparator model feeding the core.
// Assumes good_i is set by the bench between pulses.
`default_nettype none
module osc_ramp_model (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic good_i,
  output logic      osc_pulse_o,
  output logic      ramp_at_90pct_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] div_r;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) div_r <= 3'h0;
    else div_r <= div_r + 3'h1;
  end
  // Short period keeps the run brief
  assign osc_pulse_o = (div_r == 3'h7);
  assign ramp_at_90pct_o = good_i;
endmodule : osc_ramp_model
`default_nettype wire

// File: buck_undervoltage_lockout_startup_sequencer_bench.sv
// Self-checking bench for the sequencing core.
// Assumes the oscillator model pulses every eight clocks.
`default_nettype none
module buck_undervoltage_lockout_startup_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, good = 0, sync = 0, pwm = 0, zc = 0, osc, ramp, pg, dis, cen, uv, rs, os;
  seq_pkg::ss_level_t lvl = 3'h0;
  seq_pkg::variant_t  var_s = seq_pkg::VAR_PREBIAS;
  seq_pkg::gate_en_t  gate;
  int n_mismatch = 0, n_compared = 0, n;
  osc_ramp_model osc_ramp_model_i (.ref_clk_i(clk), .rst_b_i(rst_b), .good_i(good), .osc_pulse_o(osc),
    .ramp_at_90pct_o(ramp));
  buck_undervoltage_lockout_startup_sequencer buck_undervoltage_lockout_startup_sequencer_i (.ref_clk_i(clk), .rst_b_i(rst_b), .osc_pulse_i(osc),
    .sync_in_i(sync), .ramp_at_90pct_i(ramp), .ss_level_i(lvl), .variant_i(var_s), .pwm_high_i(pwm),
    .zero_current_i(zc), .osc_sync_o(os), .ramp_start_o(rs), .power_good_o(pg), .ss_discharge_o(dis),
    .core_enable_o(cen), .uv_cycle_o(uv), .gate_en_o(gate));
  initial forever #25 clk = ~clk;
  task chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task pulses(input int k, input logic g);
    repeat (k) begin
      do @(negedge clk); while (osc !== 1'b1);
      chk("ramp start", rs, 4'h1);
    end
    @(posedge clk) good <= g;
  endtask : pulses
  task count_to(input logic want);
    n = 0;
    repeat (200) begin
      @(negedge clk);
      if (pg === want) break;
      if (osc === 1'b1) n++;
    end
  endtask : count_to
  task settle(input int k);
    repeat (k) @(negedge clk);
  endtask : settle
  task reset_to(input seq_pkg::variant_t v);
    @(posedge clk) begin var_s <= v; rst_b <= 0; lvl <= 3'h0; good <= 0; pwm <= 0; zc <= 0; end
    repeat (16) @(posedge clk);
    rst_b <= 1;
    @(posedge clk) lvl <= 3'h7;
  endtask : reset_to
  task t_start();
    pulses(2, 1'b1);
    pulses(6, 1'b0); // Six good, then one bad clears the count
    pulses(1, 1'b1);
    settle(1);
    chk("early pg", pg, 0);
    count_to(1'b1);
    chk("good count", n[3:0], 7);
    chk("discharge", dis, 0);
    chk("gates", gate, 0);
    settle(3);
    chk("prebias gates", gate, 0);
    @(posedge clk) pwm <= 1;
    settle(2);
    chk("high side", gate, 2);
    @(posedge clk) pwm <= 0;
    settle(2);
    chk("rectifier", gate, 1);
    @(posedge clk) sync <= 1;
    settle(1);
    chk("sync edge", os, 1);
    @(posedge clk) sync <= 0; // Grounded when unused
    settle(1);
    chk("sync idle", os, 4'h0);
  endtask : t_start
  task t_run_checks();
    @(posedge clk) lvl <= 3'h6;
    settle(2);
    chk("switch stop", {cen, gate}, 3'h4);
    @(posedge clk) begin lvl <= 3'h7; good <= 0; end
    count_to(1'b0);
    chk("bad count", n[3:0], 7);
    chk("uv state", {dis, uv, gate}, 4'hc);
    @(posedge clk) lvl <= 3'h2;
    settle(2);
    chk("hysteresis", cen, 1);
    @(posedge clk) lvl <= 3'h0;
    settle(2);
    chk("shutdown", {cen, pg}, 0);
  endtask : t_run_checks
  task t_variant(input seq_pkg::variant_t v, input logic exp_low);
    reset_to(v);
    @(posedge clk) good <= 1;
    count_to(1'b1);
    chk("variant pg", pg, 4'h1);
    @(posedge clk) pwm <= 1;
    settle(3);
    @(posedge clk) begin pwm <= 0; zc <= 1; end
    settle(2);
    chk("zero current", gate, {1'b0, exp_low});
  endtask : t_variant
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    reset_to(seq_pkg::VAR_PREBIAS);
    t_start();
    t_run_checks();
    t_variant(seq_pkg::VAR_SOURCE_ONLY, 1'b0);
    t_variant(seq_pkg::VAR_SOURCE_SINK, 1'b1);
    wrap_up();
  end
endmodule : buck_undervoltage_lockout_startup_sequencer_bench
`default_nettype wire
